// file: rtl/omc_top.sv
`timescale 1ns/1ps
`default_nettype none
module omc_top
   import omc_pkg::*;
(
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_link_clk,
   input wire logic i_scl,
   input wire logic i_sda,
   output logic o_sda,
   output logic o_sda_oe,
   input wire logic i_tx_disable,
   input wire logic i_power_low,
   input wire logic i_power_high,
   input wire logic i_signal_absent,
   input wire logic [15:0] i_mon_temp,
   input wire logic [15:0] i_mon_vcc,
   input wire logic [15:0] i_mon_bias,
   input wire logic [15:0] i_mon_txpwr,
   input wire logic [15:0] i_mon_rxpwr,
   output logic o_tx_enable,
   output logic o_tx_fault,
   output logic o_tx_fault_oe,
   output logic o_receive_signal_lost
);
   typedef enum logic [8:0] {
      OMC_IDLE = 9'h001,
      OMC_ADDR = 9'h002,
      OMC_ACKA = 9'h004,
      OMC_PTR = 9'h008,
      OMC_ACKW = 9'h010,
      OMC_WDATA = 9'h020,
      OMC_RDATA = 9'h040,
      OMC_ACKR = 9'h080,
      OMC_ACKP = 9'h100
   } omc_state_e;

   ////////////////////////////////////////////////////////////////////////
   // system domain: pins, disable and fault
   logic [3:0] pins_s;
   logic pin_s;
   logic pwr_bad;
   logic los_s;
   logic swdis_s;
   logic pin_p_q;
   logic fault_q;
   logic fault_d;
   logic tx_en_q;
   logic tx_en_d;
   logic los_q;
   logic fault_oe_q;
   logic pin_fall;
   logic eff_dis;
   logic fault_set;
   logic sw_dis_q;

   omc_sync #(.W(4), .RST_VAL(OMC_PIN_RST)) u_pin_sync (
      .i_clk(i_sys_clk),
      .i_rst(i_srst),
      .i_d({i_signal_absent, i_power_high, i_power_low, i_tx_disable}),
      .o_q(pins_s)
   );

   omc_sync #(.W(1), .RST_VAL(OMC_SWDIS_RST)) u_swdis_sync (
      .i_clk(i_sys_clk),
      .i_rst(i_srst),
      .i_d(sw_dis_q),
      .o_q(swdis_s)
   );

   // pin resets to asserted: a floating pin keeps the laser dark
   assign pin_s = pins_s[0];
   assign pwr_bad = pins_s[1] | pins_s[2];
   assign los_s = pins_s[3];
   assign pin_fall = pin_p_q & ~pin_s;
   assign eff_dis = pin_s | swdis_s;
   // only judge power while lasing; a dark laser is always under range
   assign fault_set = pwr_bad & tx_en_q;
   // set wins over the clearing toggle
   assign fault_d = fault_set | (fault_q & ~pin_fall);
   assign tx_en_d = ~eff_dis & ~fault_d;

   always_ff @(posedge i_sys_clk)
   begin
      if (i_srst)
      begin
         pin_p_q <= 1'b1;
         fault_q <= 1'b0;
         tx_en_q <= 1'b0;
         los_q <= 1'b0;
         fault_oe_q <= 1'b1;
      end
      else
      begin
         pin_p_q <= pin_s;
         fault_q <= fault_d;
         tx_en_q <= tx_en_d;
         los_q <= los_s;
         fault_oe_q <= ~fault_d; // open collector: release means fault
      end
   end

   assign o_tx_enable = tx_en_q;
   assign o_tx_fault = fault_q;
   assign o_tx_fault_oe = fault_oe_q;
   assign o_receive_signal_lost = los_q;

   ////////////////////////////////////////////////////////////////////////
   // link domain reset and input sampling
   logic lrst1_q;
   logic lrst_q;
   logic [1:0] bus_s;
   logic scl_s;
   logic sda_s;
   logic scl_p_q;
   logic sda_p_q;
   logic [2:0] stat_s;
   logic [OMC_MON_W-1:0] mon_q;

   always_ff @(posedge i_link_clk)
   begin
      lrst1_q <= i_srst;
      lrst_q <= lrst1_q;
   end

   omc_sync #(.W(2), .RST_VAL(2'h3)) u_bus_sync (
      .i_clk(i_link_clk),
      .i_rst(lrst_q),
      .i_d({i_scl, i_sda}),
      .o_q(bus_s)
   );

   omc_sync #(.W(3), .RST_VAL(OMC_STAT_RST)) u_stat_sync (
      .i_clk(i_link_clk),
      .i_rst(lrst_q),
      .i_d({pin_s, fault_q, los_q}),
      .o_q(stat_s)
   );

   // monitors snapshot as one word so high and low bytes match
   omc_xfer #(.W(OMC_MON_W)) u_mon_xfer (
      .i_src_clk(i_sys_clk),
      .i_src_rst(i_srst),
      .i_data({i_mon_temp, i_mon_vcc, i_mon_bias, i_mon_txpwr, i_mon_rxpwr}),
      .i_dst_clk(i_link_clk),
      .i_dst_rst(lrst_q),
      .o_data(mon_q)
   );

   assign scl_s = bus_s[1];
   assign sda_s = bus_s[0];

   ////////////////////////////////////////////////////////////////////////
   // page read data
   logic [7:0] mon_b [0:9];
   logic [7:0] user_mem [0:127];
   logic [7:0] ptr_q;
   logic page_q;
   logic [7:0] mon_idx;
   logic in_mon;
   logic in_user;
   logic [7:0] stat_byte;
   logic [7:0] diag_byte;
   logic [7:0] id_byte;
   logic [7:0] rd_byte;

   genvar gi;
   generate
      for (gi = 0; gi < 10; gi++)
      begin : g_mon
         assign mon_b[gi] = mon_q[OMC_MON_W-1-8*gi -: 8];
      end
   endgenerate

   assign mon_idx = ptr_q - OMC_MON_OFS;
   assign in_mon = (ptr_q >= OMC_MON_OFS) && (mon_idx < {4'h0, OMC_MON_BYTES});
   assign in_user = (ptr_q >= OMC_USER_OFS);
   // live status, recomputed on every read
   assign stat_byte = {stat_s[2], sw_dis_q, 3'h0, stat_s[1], stat_s[0], 1'b0};
   assign diag_byte = (ptr_q == OMC_STAT_OFS) ? stat_byte :
                      in_mon ? mon_b[mon_idx[3:0]] :
                      in_user ? user_mem[ptr_q[6:0]] : 8'h00;
   assign id_byte = (ptr_q == 8'h00) ? OMC_ID_BYTE0 : 8'h00;
   assign rd_byte = page_q ? diag_byte : id_byte;

   ////////////////////////////////////////////////////////////////////////
   // two-wire slave
   omc_state_e st_q;
   omc_state_e st_d;
   logic [3:0] cnt_q;
   logic [3:0] cnt_d;
   logic [7:0] sh_q;
   logic [7:0] sh_d;
   logic [7:0] ptr_d;
   logic page_d;
   logic rw_q;
   logic rw_d;
   logic nack_q;
   logic nack_d;
   logic drv_q;
   logic drv_d;
   logic wr_en;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;
   logic addr_hit;
   logic byte_done;

   assign scl_rise = scl_s & ~scl_p_q;
   assign scl_fall = ~scl_s & scl_p_q;
   assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
   assign bus_stop = scl_s & scl_p_q & ~sda_p_q & sda_s;
   assign addr_hit = (sh_q[7:1] == OMC_ID_DEV) || (sh_q[7:1] == OMC_DIAG_DEV);
   assign byte_done = scl_fall && (cnt_q == 4'h8);

   always_comb
   begin
      st_d = st_q;
      cnt_d = cnt_q;
      sh_d = sh_q;
      ptr_d = ptr_q;
      page_d = page_q;
      rw_d = rw_q;
      nack_d = nack_q;
      drv_d = drv_q;
      wr_en = 1'b0;
      if (bus_stop)
      begin
         st_d = OMC_IDLE;
         drv_d = 1'b0;
      end
      else if (bus_start)
      begin
         st_d = OMC_ADDR;
         cnt_d = 4'h0;
         drv_d = 1'b0;
      end
      else
      begin
         unique case (st_q)
            OMC_IDLE:
            begin
            end
            OMC_ADDR, OMC_PTR, OMC_WDATA:
            begin
               if (scl_rise)
               begin
                  sh_d = {sh_q[6:0], sda_s};
                  cnt_d = cnt_q + 4'h1;
               end
               else if (byte_done)
               begin
                  cnt_d = 4'h0;
                  drv_d = 1'b1;
                  if (st_q == OMC_ADDR)
                  begin
                     page_d = sh_q[1];
                     rw_d = sh_q[0];
                     st_d = addr_hit ? OMC_ACKA : OMC_IDLE;
                     drv_d = addr_hit;
                  end
                  else if (st_q == OMC_PTR)
                  begin
                     ptr_d = sh_q;
                     st_d = OMC_ACKP;
                  end
                  else
                  begin
                     wr_en = 1'b1;
                     ptr_d = ptr_q + 8'h01;
                     st_d = OMC_ACKW;
                  end
               end
            end
            OMC_ACKA:
            begin
               if (scl_fall && rw_q)
               begin
                  sh_d = rd_byte;
                  drv_d = ~rd_byte[7];
                  cnt_d = 4'h0;
                  st_d = OMC_RDATA;
               end
               else if (scl_fall)
               begin
                  drv_d = 1'b0;
                  st_d = OMC_PTR;
               end
            end
            OMC_ACKP, OMC_ACKW:
            begin
               if (scl_fall)
               begin
                  drv_d = 1'b0;
                  st_d = OMC_WDATA;
               end
            end
            OMC_RDATA:
            begin
               if (scl_rise)
               begin
                  cnt_d = cnt_q + 4'h1;
               end
               else if (byte_done)
               begin
                  drv_d = 1'b0;
                  ptr_d = ptr_q + 8'h01;
                  st_d = OMC_ACKR;
               end
               else if (scl_fall)
               begin
                  sh_d = {sh_q[6:0], 1'b0};
                  drv_d = ~sh_q[6];
               end
            end
            OMC_ACKR:
            begin
               if (scl_rise)
               begin
                  nack_d = sda_s;
               end
               else if (scl_fall && nack_q)
               begin
                  st_d = OMC_IDLE;
               end
               else if (scl_fall)
               begin
                  sh_d = rd_byte;
                  drv_d = ~rd_byte[7];
                  cnt_d = 4'h0;
                  st_d = OMC_RDATA;
               end
            end
            default:
            begin
               st_d = OMC_IDLE;
               drv_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_link_clk)
   begin
      if (lrst_q)
      begin
         st_q <= OMC_IDLE;
         cnt_q <= 4'h0;
         sh_q <= 8'h00;
         ptr_q <= 8'h00;
         page_q <= 1'b0;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         drv_q <= 1'b0;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
      end
      else
      begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         sh_q <= sh_d;
         ptr_q <= ptr_d;
         page_q <= page_d;
         rw_q <= rw_d;
         nack_q <= nack_d;
         drv_q <= drv_d;
         scl_p_q <= scl_s;
         sda_p_q <= sda_s;
      end
   end

   // open drain: only ever pulls low
   assign o_sda = 1'b0;
   assign o_sda_oe = drv_q;

   ////////////////////////////////////////////////////////////////////////
   // host writes: software disable and user scratch area
   logic wr_stat;
   logic wr_user;

   assign wr_stat = wr_en && page_q && (ptr_q == OMC_STAT_OFS);
   assign wr_user = wr_en && page_q && in_user;

   // reset clears it, so a re-plugged module comes up enabled
   always_ff @(posedge i_link_clk)
   begin
      if (lrst_q)
      begin
         sw_dis_q <= OMC_SWDIS_RST;
      end
      else if (wr_stat)
      begin
         sw_dis_q <= sh_q[OMC_SWDIS_BIT]; // status bits are read-only
      end
   end

   // no reset: contents are undefined until the host writes them
   always_ff @(posedge i_link_clk)
   begin
      if (wr_user)
      begin
         user_mem[ptr_q[6:0]] <= sh_q;
      end
   end
endmodule : omc_top
`default_nettype wire

// file: rtl/omc_pkg.sv
package omc_pkg;
   // two-wire device addresses, 7-bit form
   localparam logic [6:0] OMC_ID_DEV = 7'h50;
   localparam logic [6:0] OMC_DIAG_DEV = 7'h51;
   // diagnostic page layout
   localparam logic [7:0] OMC_STAT_OFS = 8'h6e;
   localparam logic [7:0] OMC_MON_OFS = 8'h60;
   localparam logic [3:0] OMC_MON_BYTES = 4'ha;
   localparam logic [7:0] OMC_USER_OFS = 8'h80;
   localparam int OMC_PIN_BIT = 7;
   localparam int OMC_SWDIS_BIT = 6;
   localparam int OMC_FAULT_BIT = 2;
   localparam int OMC_LOS_BIT = 1;
   localparam logic OMC_SWDIS_RST = 1'b0;
   // identification page first byte; value is arbitrary
   localparam logic [7:0] OMC_ID_BYTE0 = 8'h5a;
   // pin sync reset: disable pin reads asserted until driven
   localparam logic [3:0] OMC_PIN_RST = 4'h1;
   localparam logic [2:0] OMC_STAT_RST = 3'h4;
   localparam int OMC_MON_W = 80;
endpackage : omc_pkg

// file: rtl/omc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module omc_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;
   logic [W-1:0] s3_q;
   logic [W-1:0] out_q;
   logic [W-1:0] out_d;

   // a bit changes only once stages two and three agree
   assign out_d = (s2_q & ~(s2_q ^ s3_q)) | (out_q & (s2_q ^ s3_q));
   assign o_q = out_q;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         out_q <= RST_VAL;
      end
      else
      begin
         s1_q <= i_d;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end
endmodule : omc_sync
`default_nettype wire

// file: rtl/omc_xfer.sv
`timescale 1ns/1ps
`default_nettype none
module omc_xfer #(
   parameter int W = 8
) (
   input wire logic i_src_clk,
   input wire logic i_src_rst,
   input wire logic [W-1:0] i_data,
   input wire logic i_dst_clk,
   input wire logic i_dst_rst,
   output logic [W-1:0] o_data
);
   logic req_q;
   logic req_s;
   logic ack_q;
   logic ack_s;
   logic [W-1:0] hold_q;
   logic [W-1:0] data_q;
   logic src_take;
   logic dst_take;

   // free-running toggle handshake; hold is stable while ack is in flight
   assign src_take = req_s ^ ack_q;
   assign dst_take = ~(ack_s ^ req_q);
   assign o_data = data_q;

   omc_sync #(.W(1), .RST_VAL(1'b0)) u_req (
      .i_clk(i_src_clk),
      .i_rst(i_src_rst),
      .i_d(req_q),
      .o_q(req_s)
   );

   omc_sync #(.W(1), .RST_VAL(1'b0)) u_ack (
      .i_clk(i_dst_clk),
      .i_rst(i_dst_rst),
      .i_d(ack_q),
      .o_q(ack_s)
   );

   always_ff @(posedge i_src_clk)
   begin
      if (i_src_rst)
      begin
         ack_q <= 1'b0;
         hold_q <= '0;
      end
      else if (src_take)
      begin
         ack_q <= req_s;
         hold_q <= i_data;
      end
   end

   always_ff @(posedge i_dst_clk)
   begin
      if (i_dst_rst)
      begin
         req_q <= 1'b0;
         data_q <= '0;
      end
      else if (dst_take)
      begin
         req_q <= ~req_q;
         data_q <= hold_q;
      end
   end
endmodule : omc_xfer
`default_nettype wire

// file: bench/omc_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module omc_top_asserts (
   input wire logic i_sys_clk,
   input wire logic i_srst,
   input wire logic i_tx_disable,
   input wire logic i_power_low,
   input wire logic i_power_high,
   input wire logic i_signal_absent,
   input wire logic o_tx_enable,
   input wire logic o_tx_fault,
   input wire logic o_tx_fault_oe,
   input wire logic o_receive_signal_lost
);
   logic [3:0] low_cnt_q;
   logic [3:0] low_cnt_d;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since the pin fell; saturates so a long-low pin can never clear
   assign low_cnt_d = i_tx_disable ? 4'h0 : (&low_cnt_q ? low_cnt_q : low_cnt_q + 4'h1);
   always_ff @(posedge i_sys_clk)
   begin
      low_cnt_q <= low_cnt_d;
   end
   ////////////////////////////////////////////////////////////////////////////
   a_fault_oe_inv: assert property (o_tx_fault_oe == !o_tx_fault)
      else $error("fault drive enable not inverse of fault");
   a_fault_laser_off: assert property (o_tx_fault [*2] |-> !o_tx_enable)
      else $error("laser on while fault latched");
   a_pin_laser_off: assert property (i_tx_disable [*7] |-> !o_tx_enable)
      else $error("laser on while disable pin high");
   a_fault_sets: assert property (
      (i_power_low || i_power_high) && o_tx_enable |-> ##[1:8] o_tx_fault)
      else $error("power out of range did not raise fault");
   a_fault_latch: assert property (
      $fell(o_tx_fault) |-> low_cnt_q inside {[4'h2:4'ha]})
      else $error("fault cleared without a disable pin cycle");
   a_enable_rise: assert property (
      $rose(o_tx_enable) |-> !o_tx_fault && !$past(i_tx_disable))
      else $error("laser enabled without pin low");
   a_los_set: assert property (i_signal_absent [*8] |-> o_receive_signal_lost)
      else $error("signal lost output not raised");
   a_los_clear: assert property (!i_signal_absent [*8] |-> !o_receive_signal_lost)
      else $error("signal lost output stuck high");
endmodule : omc_top_asserts
`default_nettype wire

// file: bench/omc_host.sv
`timescale 1ns/1ps
`default_nettype none
module omc_host (
   output logic o_scl,
   output logic o_pull,
   input wire logic i_sda
);
   // quarter bit; keeps the low phase well above eight link clocks
   localparam int QTR = 400;
   initial
   begin
      o_scl = 1'b1;
      o_pull = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // also serves as repeated start from a low clock phase
   task automatic start();
      o_pull = 1'b0;
      #QTR o_scl = 1'b1;
      #QTR o_pull = 1'b1;
      #QTR o_scl = 1'b0;
      #QTR;
   endtask : start
   task automatic stop();
      o_pull = 1'b1;
      #QTR o_scl = 1'b1;
      #QTR o_pull = 1'b0;
      #QTR;
   endtask : stop
   // eight bits msb first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
      output logic ack_out);
      logic [8:0] sh;
      sh = {tx, ack_in};
      for (int i = 8; i >= 0; i--)
      begin
         o_pull = !sh[i];
         #QTR o_scl = 1'b1;
         #QTR sh[i] = i_sda;
         #QTR o_scl = 1'b0;
         #QTR;
      end
      rx = sh[8:1];
      ack_out = sh[0];
   endtask : xfer
   task automatic access(input logic [6:0] dev, input logic [7:0] ofs, input logic wr,
      input logic [7:0] wd, output logic [7:0] rd, output logic ok);
      logic [7:0] r;
      logic [3:0] a;
      a = 4'h0;
      start();
      xfer({dev, 1'b0}, 1'b1, r, a[0]);
      xfer(ofs, 1'b1, r, a[1]);
      if (wr)
      begin
         xfer(wd, 1'b1, r, a[2]);
      end
      else
      begin
         start();
         xfer({dev, 1'b1}, 1'b1, r, a[2]);
         xfer(8'hff, 1'b1, rd, a[3]);
      end
      stop();
      ok = (a[2:0] === 3'h0);
   endtask : access
endmodule : omc_host
`default_nettype wire

// file: bench/tb_omc_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
   begin \
      checks_done++; \
      if ((a) !== (e)) \
      begin \
         errors++; \
         $display("CHECK FAILED at %0t got %h expected %h", $time, (a), (e)); \
      end \
   end
module tb_omc_top
   import omc_pkg::*;
;
   logic sys_clk = 1'b0;
   logic link_clk = 1'b0;
   logic srst = 1'b1;
   logic pin = 1'b1;
   logic plow = 1'b0;
   logic phigh = 1'b0;
   logic absent = 1'b0;
   logic [79:0] mon = 80'h1234_5678_9abc_def0_0f1e;
   logic scl, pull, sda, sda_out, sda_oe, tx_en, flt, flt_oe, lost, ok;
   logic [7:0] d;
   int errors = 0;
   int checks_done = 0;
   always #25 sys_clk = ~sys_clk;
   always #16 link_clk = ~link_clk;
   // open-drain bus with pull-up
   assign sda = !pull && (sda_oe ? sda_out : 1'b1);
   omc_top dut (
      .i_sys_clk(sys_clk), .i_srst(srst), .i_link_clk(link_clk), .i_scl(scl),
      .i_sda(sda), .o_sda(sda_out), .o_sda_oe(sda_oe), .i_tx_disable(pin),
      .i_power_low(plow), .i_power_high(phigh), .i_signal_absent(absent),
      .i_mon_temp(mon[79:64]), .i_mon_vcc(mon[63:48]), .i_mon_bias(mon[47:32]),
      .i_mon_txpwr(mon[31:16]), .i_mon_rxpwr(mon[15:0]), .o_tx_enable(tx_en),
      .o_tx_fault(flt), .o_tx_fault_oe(flt_oe), .o_receive_signal_lost(lost)
   );
   omc_host host (.o_scl(scl), .o_pull(pull), .i_sda(sda));
   ////////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : cyc
   task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] exp);
      host.access(dev, ofs, 1'b0, 8'h00, d, ok);
      `CHK(ok, 1'b1)
      `CHK(d, exp)
   endtask : rd
   task automatic wr(input logic [7:0] ofs, input logic [7:0] wd);
      host.access(OMC_DIAG_DEV, ofs, 1'b1, wd, d, ok);
      `CHK(ok, 1'b1)
      cyc(12);
   endtask : wr
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0)
      begin
         $display("Simulation passed");
      end
      else
      begin
         $display("Simulation failed");
      end
      $finish;
   endtask : report_and_stop
   ////////////////////////////////////////////////////////////////////////////
   initial
   begin
      cyc(8);
      `CHK({tx_en, flt, flt_oe, lost}, 4'h2)
      srst = 1'b0;
      cyc(20);
      `CHK(tx_en, 1'b0)
      pin = 1'b0;
      cyc(12);
      `CHK(tx_en, 1'b1)
      rd(OMC_ID_DEV, 8'h00, OMC_ID_BYTE0);
      rd(OMC_ID_DEV, OMC_STAT_OFS, 8'h00);
      rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h00);
      for (int i = 0; i < 10; i++)
      begin
         rd(OMC_DIAG_DEV, OMC_MON_OFS + 8'(i), mon[79-8*i -: 8]);
      end
      host.access(7'h52, OMC_STAT_OFS, 1'b0, 8'h00, d, ok);
      `CHK(ok, 1'b0)
      wr(OMC_STAT_OFS, 8'hff);
      `CHK(tx_en, 1'b0)
      rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h40);
      wr(OMC_STAT_OFS, 8'h00);
      `CHK(tx_en, 1'b1)
      // id page ignores writes; scratch area lives only in the diagnostic page
      host.access(OMC_ID_DEV, OMC_STAT_OFS, 1'b1, 8'h40, d, ok);
      `CHK(ok, 1'b1)
      rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h00);
      wr(OMC_USER_OFS, 8'h3c);
      rd(OMC_DIAG_DEV, OMC_USER_OFS, 8'h3c);
      rd(OMC_ID_DEV, OMC_USER_OFS, 8'h00);
      // monitors must follow their inputs, not stay at the first snapshot
      mon = 80'h0f1e_2d3c_4b5a_6978_8796;
      cyc(40);
      rd(OMC_DIAG_DEV, OMC_MON_OFS, mon[79:72]);
      rd(OMC_DIAG_DEV, OMC_MON_OFS + 8'h09, mon[7:0]);
      absent = 1'b1;
      cyc(12);
      `CHK(lost, 1'b1)
      rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h02);
      absent = 1'b0;
      cyc(12);
      `CHK(lost, 1'b0)
      // under range, then over range
      for (int i = 0; i < 2; i++)
      begin
         {phigh, plow} = i ? 2'b10 : 2'b01;
         cyc(12);
         {phigh, plow} = 2'b00;
         cyc(20);
         `CHK({tx_en, flt, flt_oe}, 3'b010)
         rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h04);
         pin = 1'b1;
         cyc(12);
         rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h84);
         pin = 1'b0;
         cyc(12);
         `CHK({tx_en, flt, flt_oe}, 3'b101)
      end
      wr(OMC_STAT_OFS, 8'h40);
      `CHK(tx_en, 1'b0)
      srst = 1'b1;
      cyc(8);
      srst = 1'b0;
      cyc(20);
      `CHK(tx_en, 1'b1)
      rd(OMC_DIAG_DEV, OMC_STAT_OFS, 8'h00);
      report_and_stop();
   end
   initial
   begin
      #4000000;
      errors++;
      report_and_stop();
   end
endmodule : tb_omc_top
bind omc_top omc_top_asserts chk (
   .i_sys_clk(i_sys_clk), .i_srst(i_srst), .i_tx_disable(i_tx_disable),
   .i_power_low(i_power_low), .i_power_high(i_power_high),
   .i_signal_absent(i_signal_absent), .o_tx_enable(o_tx_enable),
   .o_tx_fault(o_tx_fault), .o_tx_fault_oe(o_tx_fault_oe),
   .o_receive_signal_lost(o_receive_signal_lost)
);
`default_nettype wire
